// ===== xd_dispatch.sv
// exception recognition, priority and vectoring
`timescale 1ns/1ps
`default_nettype none
`include "xd_defines.svh"
module xd_dispatch
  import xd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // pins from system logic; the five _n pins are active low and asynchronous
  input  wire logic        hard_reset_n_i,
  input  wire logic        soft_reset_n_i,
  input  wire logic        power_on_reset_i,
  input  wire logic        transfer_error_ack_n_i,
  input  wire logic        data_bus_busy_i,
  input  wire logic        machine_check_pin_n_i,
  input  wire logic        ext_irq_n_i,
  // core side, same clock
  input  wire logic        ecc_double_err_i,
  input  wire logic        data_access_fault_i,
  input  wire logic        fetch_access_fault_i,
  input  wire logic        align_fault_i,
  input  wire logic        program_fault_i,
  input  wire logic        fp_unavail_i,
  input  wire logic        system_call_i,
  input  wire logic        countdown_msb_i,
  input  wire logic        event_limit_i,
  input  wire logic        heat_over_limit_i,
  input  wire logic        heat_mgmt_en_i,
  input  wire logic        complete_i,
  input  wire logic        complete_branch_i,
  input  wire logic        complete_ctx_sync_i,
  input  wire logic [31:0] complete_pc_i,
  input  wire logic [31:0] next_pc_i,
  input  wire logic        units_empty_i,
  input  wire logic        restart_known_i,
  input  wire logic        handler_return_i,
  input  wire logic [31:0] handler_addr_i,
  output logic             cancel_o,
  output logic             redirect_o,
  output logic      [31:0] fetch_addr_o,
  output logic      [19:0] vector_o
);
  xd_regs_t q, d;

  logic        hr, sr, machine_check_pin_n, transfer_error_ack_n, irq;
  logic        sync_hit, async_hit, mchk, rst_hit, dec_rise, brk_hit, trc_hit;
  logic [19:0] s_vec, a_vec;
  logic [31:0] wmask;
  logic [3:0]  idx;

  // second stage of each pin synchroniser, never the first
  assign hr  = ~q.s_hr[1];
  assign sr  = ~q.s_sr[1];
  assign machine_check_pin_n = ~q.s_mcp[1];
  assign transfer_error_ack_n = ~q.s_tea[1];
  assign irq = ~q.s_int[1];
  assign idx = wb_adr_i[5:2];

  always_comb begin
    d = q;
    // edge history bits after the second stage are reserved for edge use
    d.s_hr  = {q.s_hr[1:0], hard_reset_n_i};
    d.s_sr  = {q.s_sr[1:0], soft_reset_n_i};
    d.s_mcp = {q.s_mcp[1:0], machine_check_pin_n_i};
    d.s_tea = {q.s_tea[1:0], transfer_error_ack_n_i};
    d.s_int = {q.s_int[1:0], ext_irq_n_i};
    d.dec_msb  = countdown_msb_i;
    d.redirect = 1'b0;
    d.ack      = 1'b0;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    rst_hit  = hr | sr | power_on_reset_i;
    mchk     = q.machine_state_reg[`XD_MCHECK_ALLOW] & ((transfer_error_ack_n & data_bus_busy_i) | machine_check_pin_n | ecc_double_err_i);
    dec_rise = countdown_msb_i & ~q.dec_msb;
    brk_hit  = q.brk[`XD_BRK_BE] & (q.brk[31:2] == next_pc_i[31:2])
             & (q.brk[`XD_BRK_TE] == q.machine_state_reg[`XD_FETCH_XLAT_ON]);
    // context synchronize completes without tracing
    trc_hit  = complete_i & ~complete_ctx_sync_i
             & (q.machine_state_reg[`XD_STEP_TRACE_EN] | (complete_branch_i & q.machine_state_reg[`XD_BRANCH_TRACE_EN]));

    // instruction causes, fixed priority; float faults arrive precise in every mode
    sync_hit = 1'b1;
    if (fetch_access_fault_i)     s_vec = `XD_VEC_FACCESS;
    else if (brk_hit)             s_vec = `XD_VEC_BREAK;
    else if (align_fault_i)       s_vec = `XD_VEC_ALIGN;
    else if (data_access_fault_i) s_vec = `XD_VEC_DACCESS;
    else if (program_fault_i)     s_vec = `XD_VEC_PROGRAM;
    else if (fp_unavail_i)        s_vec = `XD_VEC_FPUNAV;
    else if (system_call_i)       s_vec = `XD_VEC_SYSCALL;
    else if (trc_hit)             s_vec = `XD_VEC_TRACE;
    else begin
      s_vec    = 20'h00000;
      sync_hit = 1'b0;
    end

    // maskable sources all gated by enable bits
    async_hit = 1'b1;
    if (irq & q.machine_state_reg[`XD_EXT_IRQ_ALLOW])               a_vec = `XD_VEC_EXT;
    else if (dec_rise & q.machine_state_reg[`XD_EXT_IRQ_ALLOW])     a_vec = `XD_VEC_DECR;
    else if (event_limit_i & q.mon_en)         a_vec = `XD_VEC_PERFMON;
    else if (heat_mgmt_en_i & heat_over_limit_i & q.machine_state_reg[`XD_EXT_IRQ_ALLOW])
                                               a_vec = `XD_VEC_THERMAL;
    else begin
      a_vec     = 20'h00000;
      async_hit = 1'b0;
    end

    case (q.st)
      XD_RUN: begin
        if (rst_hit) begin
          d.vec     = `XD_VEC_RESET;
          d.save_pc = complete_pc_i;
          d.save_st = q.machine_state_reg;
          d.machine_state_reg     = `XD_MSR_RESET;
          d.st      = XD_TAKE;
        end else if (mchk) begin
          d.vec     = `XD_VEC_MCHECK;
          d.save_pc = complete_pc_i;
          d.save_st = q.machine_state_reg;
          d.machine_state_reg     = q.machine_state_reg & ~(32'h1 << `XD_RECOVERABLE_FLAG) & ~(32'h1 << `XD_MCHECK_ALLOW) & ~32'h1;
          d.st      = XD_TAKE;
        end else if (sync_hit) begin
          d.vec     = s_vec;
          // faulting address given; only a system call returns past itself
          d.save_pc = (system_call_i & s_vec == `XD_VEC_SYSCALL) ? next_pc_i
                      : complete_pc_i;
          d.save_st = q.machine_state_reg;
          d.machine_state_reg     = (q.machine_state_reg & ~32'h0000003d) | (32'h1 << `XD_RECOVERABLE_FLAG);
          d.st      = XD_TAKE;
        end else if (async_hit) begin
          d.vec = a_vec;
          d.st  = XD_DRAIN;
        end
      end
      XD_DRAIN: begin
        if (rst_hit | mchk | sync_hit) begin
          d.st = XD_RUN;
        end else if (complete_i | (units_empty_i & restart_known_i)) begin
          d.save_pc = complete_i ? next_pc_i : complete_pc_i;
          d.save_st = q.machine_state_reg;
          d.machine_state_reg     = (q.machine_state_reg & ~32'h0000003d) | (32'h1 << `XD_RECOVERABLE_FLAG);
          d.st      = XD_TAKE;
        end
      end
      XD_TAKE: begin
        d.cause      = q.vec;
        d.fetch_addr = q.base + {12'h000, q.vec};
        d.redirect   = 1'b1;
        d.st         = XD_RUN;
      end
      default: d.st = XD_RUN;
    endcase

    // return from handler: restore state, restart where the handler chose
    if (handler_return_i && q.st == XD_RUN) begin
      d.machine_state_reg        = q.save_st;
      d.fetch_addr = handler_addr_i;
      d.redirect   = 1'b1;
    end

    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.ack  = 1'b1;
      d.rdat = 32'h0;
      case (idx)
        `XD_ADR_STATE:  d.rdat = q.machine_state_reg;
        `XD_ADR_SAVEPC: d.rdat = q.save_pc;
        `XD_ADR_SAVEST: d.rdat = q.save_st;
        `XD_ADR_BASE:   d.rdat = q.base;
        `XD_ADR_BREAK:  d.rdat = q.brk;
        `XD_ADR_MON:    d.rdat = {31'h0, q.mon_en};
        `XD_ADR_CAUSE:  d.rdat = {12'h000, q.cause};
        `XD_ADR_HEAT:   d.rdat = {31'h0, heat_over_limit_i};
        default:        d.rdat = 32'h0;
      endcase
      if (wb_we_i) begin
        case (idx)
          `XD_ADR_STATE:  d.machine_state_reg     = (q.machine_state_reg & ~wmask) | (wb_dat_i & wmask);
          `XD_ADR_SAVEPC: d.save_pc = (q.save_pc & ~wmask) | (wb_dat_i & wmask);
          `XD_ADR_SAVEST: d.save_st = (q.save_st & ~wmask) | (wb_dat_i & wmask);
          `XD_ADR_BASE:   d.base    = (q.base & ~wmask) | (wb_dat_i & wmask);
          `XD_ADR_BREAK:  d.brk     = (q.brk & ~wmask) | (wb_dat_i & wmask);
          `XD_ADR_MON:    if (wb_sel_i[0]) d.mon_en = wb_dat_i[`XD_MON_MONITOR_IRQ_ENABLE];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q            <= '0;
      q.st         <= XD_RUN;
      q.machine_state_reg        <= `XD_MSR_RESET;
      q.base       <= `XD_BASE_RESET;
      q.s_hr       <= 3'h7;
      q.s_sr       <= 3'h7;
      q.s_mcp      <= 3'h7;
      q.s_tea      <= 3'h7;
      q.s_int      <= 3'h7;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // later instructions are squashed only while the take state XD_TAKE is held
  assign cancel_o     = (q.st == XD_TAKE);
  assign redirect_o   = q.redirect;
  assign fetch_addr_o = q.fetch_addr;
  assign vector_o     = q.cause;
  assign wb_ack_o     = q.ack;
  assign wb_dat_o     = q.rdat;

  sequence s_taking;
    ce_i && q.st == XD_TAKE;
  endsequence

  sequence s_redirected;
    redirect_o && fetch_addr_o == q.base + {12'h000, vector_o};
  endsequence

  property p_take_redirects;
    @(posedge clk_i) disable iff (rst_i)
      s_taking |=> s_redirected;
  endproperty
  a_take_redirects: assert property (p_take_redirects) else $error("no redirect after take");

  // squash must stand exactly while the take is pending, then drop with the redirect
  property p_cancel_pulse;
    @(posedge clk_i) disable iff (rst_i)
      s_taking |-> cancel_o ##1 !cancel_o;
  endproperty
  a_cancel_pulse: assert property (p_cancel_pulse) else $error("cancel not one cycle");

  property p_fetch_first;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && q.st == XD_RUN && !rst_hit && !mchk && fetch_access_fault_i)
        |=> (q.st == XD_TAKE && q.vec == `XD_VEC_FACCESS);
  endproperty
  a_fetch_first: assert property (p_fetch_first) else $error("fetch fault not vectored");

  // a handler return or a bus write also rewrites the state word, so both are left out
  property p_recover_set;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && q.st == XD_RUN && !rst_hit && !mchk && sync_hit && !handler_return_i
       && !(wb_cyc_i && wb_stb_i)) |=> q.machine_state_reg[`XD_RECOVERABLE_FLAG];
  endproperty
  a_recover_set: assert property (p_recover_set) else $error("recoverable flag not set");

  property p_async_ready;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && q.st == XD_DRAIN && !rst_hit && !mchk && !sync_hit
       && units_empty_i && restart_known_i) |=> (q.st == XD_TAKE);
  endproperty
  a_async_ready: assert property (p_async_ready) else $error("idle async not taken");

  property p_ctx_no_trace;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && q.st == XD_RUN && !rst_hit && !mchk && !brk_hit && complete_i
       && complete_ctx_sync_i && !fetch_access_fault_i && !align_fault_i
       && !data_access_fault_i && !program_fault_i && !fp_unavail_i && !system_call_i)
        |=> (q.st != XD_TAKE);
  endproperty
  a_ctx_no_trace: assert property (p_ctx_no_trace) else $error("trace on context sync");

  property p_no_reserved;
    @(posedge clk_i) disable iff (rst_i)
      (q.st == XD_TAKE) |-> (q.vec != 20'h00e00 && q.vec != 20'h00000);
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved vector chosen");

  property p_reset_first;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && q.st == XD_RUN && rst_hit) |=> (q.st == XD_TAKE && q.vec == `XD_VEC_RESET);
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("reset not highest");

  property p_mchk_gated;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && q.st == XD_RUN && !rst_hit && !q.machine_state_reg[`XD_MCHECK_ALLOW] && !sync_hit && !async_hit)
        |=> (q.st == XD_RUN);
  endproperty
  a_mchk_gated: assert property (p_mchk_gated) else $error("mcheck taken while masked");

  property p_ext_masked;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && q.st == XD_RUN && !q.machine_state_reg[`XD_EXT_IRQ_ALLOW] && !rst_hit && !mchk && !sync_hit)
        |=> (q.vec != `XD_VEC_EXT || $stable(q.vec));
  endproperty
  a_ext_masked: assert property (p_ext_masked) else $error("ext irq taken while masked");

  property p_drain_waits;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && q.st == XD_DRAIN && !complete_i && !(units_empty_i && restart_known_i)
       && !rst_hit && !mchk && !sync_hit) |=> (q.st == XD_DRAIN);
  endproperty
  a_drain_waits: assert property (p_drain_waits) else $error("async taken early");

  property p_save_state;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && q.st == XD_RUN && (rst_hit || mchk || sync_hit) && !(wb_cyc_i && wb_stb_i))
        |=> (q.save_st == $past(q.machine_state_reg));
  endproperty
  a_save_state: assert property (p_save_state) else $error("prior state not saved");

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && wb_ack_o) |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");
endmodule : xd_dispatch
`default_nettype wire

// ===== xd_defines.svh
// constants for the exception dispatch block
`ifndef XD_DEFINES_SVH
`define XD_DEFINES_SVH
`define XD_VEC_RESET    20'h00100
`define XD_VEC_MCHECK   20'h00200
`define XD_VEC_DACCESS  20'h00300
`define XD_VEC_FACCESS  20'h00400
`define XD_VEC_EXT      20'h00500
`define XD_VEC_ALIGN    20'h00600
`define XD_VEC_PROGRAM  20'h00700
`define XD_VEC_FPUNAV   20'h00800
`define XD_VEC_DECR     20'h00900
`define XD_VEC_SYSCALL  20'h00c00
`define XD_VEC_TRACE    20'h00d00
`define XD_VEC_PERFMON  20'h00f00
`define XD_VEC_BREAK    20'h01300
`define XD_VEC_THERMAL  20'h01700
`define XD_ADR_STATE    4'h0
`define XD_ADR_SAVEPC   4'h1
`define XD_ADR_SAVEST   4'h2
`define XD_ADR_BASE     4'h3
`define XD_ADR_BREAK    4'h4
`define XD_ADR_MON      4'h5
`define XD_ADR_CAUSE    4'h6
`define XD_ADR_HEAT     4'h7
`define XD_EXT_IRQ_ALLOW       0
`define XD_MCHECK_ALLOW       1
`define XD_STEP_TRACE_EN       2
`define XD_BRANCH_TRACE_EN       3
`define XD_RECOVERABLE_FLAG       4
`define XD_FETCH_XLAT_ON       5
`define XD_MSR_RESET    32'h00000000
`define XD_BRK_TE       1
`define XD_BRK_BE       0
`define XD_MON_MONITOR_IRQ_ENABLE    0
`define XD_BASE_RESET   32'h00000000
`endif

// ===== xd_pkg.sv
// types for the exception dispatch block
package xd_pkg;
  typedef enum logic [1:0] {XD_RUN, XD_DRAIN, XD_TAKE} xd_state_t;
  typedef struct packed {
    xd_state_t   st;
    logic [31:0] machine_state_reg;
    logic [31:0] save_pc;
    logic [31:0] save_st;
    logic [31:0] base;
    logic [31:0] brk;
    logic        mon_en;
    logic [19:0] cause;
    logic [19:0] vec;
    logic        dec_msb;
    logic        redirect;
    logic [31:0] fetch_addr;
    logic        ack;
    logic [31:0] rdat;
    logic [2:0]  s_hr;
    logic [2:0]  s_sr;
    logic [2:0]  s_mcp;
    logic [2:0]  s_tea;
    logic [2:0]  s_int;
  } xd_regs_t;
endpackage : xd_pkg

// ===== xd_sys_model.sv
// system logic model that drives the reset, check and interrupt pins
`timescale 1ns/1ps
`default_nettype none
module xd_sys_model (
  input  wire logic       clk_i,
  input  wire logic [4:0] assert_i,
  input  wire logic       busy_i,
  output var  logic       hard_reset_n_o,
  output var  logic       soft_reset_n_o,
  output var  logic       transfer_error_ack_n_o,
  output var  logic       machine_check_pin_n_o,
  output var  logic       ext_irq_n_o,
  output var  logic       data_bus_busy_o
);
  // the five _n pins are pulled up, so a released one reads high, never its last value; busy starts low
  initial begin
    {ext_irq_n_o, machine_check_pin_n_o, transfer_error_ack_n_o} = 3'h7;
    {soft_reset_n_o, hard_reset_n_o} = 2'h3;
    data_bus_busy_o = 1'b0;
  end
  // changes only just after an edge, like real board logic on this clock
  always @(posedge clk_i) begin
    {ext_irq_n_o, machine_check_pin_n_o, transfer_error_ack_n_o,
     soft_reset_n_o, hard_reset_n_o} <= ~assert_i;
    data_bus_busy_o <= busy_i;
  end
endmodule // xd_sys_model
`default_nettype wire

// ===== xd_tb.sv
// self-checking bench for the exception dispatch block
`timescale 1ns/1ps
`default_nettype none
`include "xd_defines.svh"
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, we = 1'b0, busy = 1'b0, por = 1'b0;
  logic        empty = 1'b0, known = 1'b0, ret = 1'b0;
  logic [31:0] adr = '0, wdat = '0, rdat, dat_o, fa;
  logic [31:0] bs = '0, cpc = 32'h0000_2000, npc = 32'h0000_2004;
  logic [13:0] c = '0;
  logic [4:0]  pa = '0;
  logic [19:0] vec;
  logic        ack, cancel, redir, hr_n, sr_n, tea_n, mcp_n, irq_n, dbb;
  int          n_mismatch = 0;
  int          n_checks = 0;
  always #2 clk_i = ~clk_i;
  xd_sys_model u_sys (.clk_i(clk_i), .assert_i(pa), .busy_i(busy), .hard_reset_n_o(hr_n),
    .soft_reset_n_o(sr_n), .transfer_error_ack_n_o(tea_n), .machine_check_pin_n_o(mcp_n),
    .ext_irq_n_o(irq_n), .data_bus_busy_o(dbb));
  xd_dispatch u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .hard_reset_n_i(hr_n), .soft_reset_n_i(sr_n), .power_on_reset_i(por),
    .transfer_error_ack_n_i(tea_n), .data_bus_busy_i(dbb), .machine_check_pin_n_i(mcp_n),
    .ext_irq_n_i(irq_n), .ecc_double_err_i(c[13]), .data_access_fault_i(c[0]),
    .fetch_access_fault_i(c[1]), .align_fault_i(c[2]), .program_fault_i(c[3]),
    .fp_unavail_i(c[4]), .system_call_i(c[5]), .countdown_msb_i(c[6]), .event_limit_i(c[7]),
    .heat_over_limit_i(c[8]), .heat_mgmt_en_i(c[9]), .complete_i(c[10]),
    .complete_branch_i(c[11]), .complete_ctx_sync_i(c[12]), .complete_pc_i(cpc),
    .next_pc_i(npc), .units_empty_i(empty), .restart_known_i(known), .handler_return_i(ret),
    .handler_addr_i(32'h0000_3000), .cancel_o(cancel), .redirect_o(redir), .fetch_addr_o(fa),
    .vector_o(vec));
  task automatic finish_test;
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    finish_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic single cycle; ack and read data are taken at the rising edge that sees ack high
  task automatic wb(input logic w, input logic [3:0] i, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {26'h0, i, 2'b00};
    wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (k == 20) hang();
    rdat = dat_o;
    cyc <= 1'b0;
  endtask
  task automatic set(input logic [13:0] v);
    @(posedge clk_i);
    c <= v;
  endtask
  task automatic waitr(output logic pc);
    int k;
    for (k = 0; k < 40; k++) begin
      @(negedge clk_i);
      if (redir === 1'b1) break;
      pc = cancel;
    end
    if (k == 40) hang();
  endtask
  task automatic take(input logic [19:0] v);
    logic pc;
    waitr(pc);
    chk({31'h0, pc}, 32'h1);
    chk(fa, bs + {12'h0, v});
    chk({12'h0, vec}, {12'h0, v});
    @(posedge clk_i);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk_i);
      chk({31'h0, redir}, 32'h0);
    end
  endtask
  task automatic t_regs;
    wb(0, 0, 0);
    chk(rdat, 32'h0);
    bs = 32'h0001_0000;
    wb(1, 3, bs);
    wb(0, 3, 0);
    chk(rdat, bs);
    wb(0, 9, 0);
    chk(rdat, 32'h0);
  endtask
  task automatic t_sync;
    logic [19:0] v [6] = '{`XD_VEC_DACCESS, `XD_VEC_FACCESS, `XD_VEC_ALIGN,
                           `XD_VEC_PROGRAM, `XD_VEC_FPUNAV, `XD_VEC_SYSCALL};
    for (int i = 0; i < 6; i++) begin
      set(14'h0400 | (14'h1 << i));
      set(14'h0);
      take(v[i]);
      wb(0, 1, 0);
      chk(rdat, (i == 5) ? npc : cpc);
    end
    wb(0, 0, 0);
    chk(rdat & 32'h10, 32'h10);
    wb(0, 2, 0);
    chk(rdat, 32'h10);
  endtask
  task automatic t_prio;
    logic pc;
    set(14'h0403);
    set(14'h0);
    take(`XD_VEC_FACCESS);
    quiet(10);
    @(posedge clk_i);
    ret <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
    waitr(pc);
    chk(fa, 32'h0000_3000);
  endtask
  // maskable events wait for the next completion while units are busy
  task automatic t_ext;
    wb(1, 0, 32'h0);
    pa <= 5'h10;
    quiet(12);
    wb(1, 0, 32'h1);
    quiet(8);
    set(14'h0400);
    set(14'h0);
    take(`XD_VEC_EXT);
    pa <= 5'h0;
    empty <= 1'b1;
    known <= 1'b1;
    // the released pin needs both synchroniser stages to clear before unmasking
    repeat (4) @(posedge clk_i);
    wb(1, 0, 32'h1);
    set(14'h0040);
    take(`XD_VEC_DECR);
    wb(1, 0, 32'h1);
    quiet(8);
    wb(1, 5, 32'h1);
    set(14'h00c0);
    set(14'h0040);
    take(`XD_VEC_PERFMON);
    wb(1, 5, 32'h0);
    wb(1, 0, 32'h1);
    set(14'h0340);
    set(14'h0240);
    take(`XD_VEC_THERMAL);
    set(14'h0);
  endtask
  task automatic t_mchk;
    wb(1, 0, 32'h0);
    busy <= 1'b1;
    pa <= 5'h04;
    quiet(10);
    wb(1, 0, 32'h2);
    take(`XD_VEC_MCHECK);
    pa <= 5'h0;
    busy <= 1'b0;
    wb(1, 0, 32'h2);
    set(14'h2000);
    set(14'h0);
    take(`XD_VEC_MCHECK);
    wb(1, 0, 32'h2);
    pa <= 5'h09;
    take(`XD_VEC_RESET);
    pa <= 5'h0;
    repeat (8) @(posedge clk_i);
    pa <= 5'h02;
    take(`XD_VEC_RESET);
    pa <= 5'h0;
    repeat (8) @(posedge clk_i);
    por <= 1'b1;
    take(`XD_VEC_RESET);
    por <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  // a wrong translation select must not match; the right one must
  task automatic t_brk;
    wb(1, 0, 32'h0);
    for (int s = 1; s >= 0; s--) begin
      wb(1, 4, {30'h0000_1000, s[0], 1'b1});
      npc <= 32'h0000_4000;
      c <= 14'h0400;
      set(14'h0);
      npc <= 32'h0000_2004;
      if (s == 1) quiet(8);
      else take(`XD_VEC_BREAK);
    end
    wb(1, 4, 32'h0);
  endtask
  task automatic t_trace;
    wb(1, 0, 32'h4);
    set(14'h1400);
    set(14'h0);
    quiet(8);
    set(14'h0400);
    set(14'h0);
    take(`XD_VEC_TRACE);
    wb(1, 0, 32'h8);
    set(14'h0c00);
    set(14'h0);
    take(`XD_VEC_TRACE);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_sync();
    t_prio();
    t_ext();
    t_mchk();
    t_brk();
    t_trace();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
